// ---- dv/swss_host_model.sv ----
// Host model: drives the host pins and the decoded sleep commands.
// Assumes callers enter its tasks 2 ns after a clock edge.
`timescale 1ns/10ps
module swss_host_model
  import swss_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // To the device
  output swss_pkg::swss_host_s host_pins_o,
  output logic usb_off_o,
  output logic slow_clk_o
);
  initial begin
    host_pins_o = '1;
    usb_off_o = 1'b0;
    slow_clk_o = 1'b0;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask
  task automatic put(input swss_host_s v);
    host_pins_o = v;
  endtask
  // Ready line first, settled past the synchroniser, then commands
  task automatic sleep_req();
    host_pins_o.terminal_ready = 1'b1;
    step(4);
    usb_off_o = 1'b1;
    step(1);
    usb_off_o = 1'b0;
    slow_clk_o = 1'b1;
    step(1);
    slow_clk_o = 1'b0;
  endtask
  task automatic wake(input bit by_dtr);
    if (by_dtr) host_pins_o.terminal_ready = 1'b0;
    else host_pins_o.wake_request = 1'b0;
    step(6);
    host_pins_o = '1;
    step(1);
  endtask
endmodule

// ---- dv/swss_top_assertions.sv ----
// Port checker for swss_top, bound at the foot of this file.
// Assumes one clock domain; the ring count comes from the bound swss_top's RING_HALF.
`timescale 1ns/10ps
module swss_top_chk
  import swss_pkg::*;
#(
  parameter int unsigned RING_HALF = 8
) (
  // Clock, reset and inputs
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire swss_pkg::swss_host_s host_pins_i,
  input wire logic ring_event_i,
  input wire logic ring_clear_i,
  input wire logic slow_clock_command_i,
  // Design outputs
  input wire logic host_wake_ring_out_o,
  input wire swss_pkg::swss_od_s network_led_out_o,
  input wire logic status_o,
  input wire logic status_oe_o,
  input wire logic asleep_o,
  input wire logic radio_on_o,
  input wire logic wake_event_o
);
  int unsigned hi_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) hi_q <= 0;
    else hi_q <= host_wake_ring_out_o ? hi_q + 1 : 0;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_woke; asleep_o ##1 !asleep_o; endsequence
  property p_idle;
    ring_clear_i && !ring_event_i |-> ##2 !host_wake_ring_out_o;
  endproperty
  a_idle: assert property (p_idle) else $error("ring");
  // A clear cuts a high phase short, so those falls are excused
  property p_half;
    $fell(host_wake_ring_out_o) && !$past(ring_clear_i, 2)
      |-> hi_q == RING_HALF;
  endproperty
  a_half: assert property (p_half) else $error("ring phase");
  property p_od; !network_led_out_o.led_o; endproperty
  a_od: assert property (p_od) else $error("led");
  property p_st; !$past(rst_i) |-> status_oe_o && !status_o; endproperty
  a_st: assert property (p_st) else $error("status");
  property p_slp;
    $rose(asleep_o) |-> $past(slow_clock_command_i);
  endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_wk;
    asleep_o && !(host_pins_i.terminal_ready && host_pins_i.wake_request)
      |-> ##[1:4] !asleep_o;
  endproperty
  a_wk: assert property (p_wk) else $error("wake");
  property p_pls; s_woke |-> wake_event_o ##1 !wake_event_o; endproperty
  a_pls: assert property (p_pls) else $error("pulse");
  property p_fl;
    $stable(host_pins_i.flight_n) [*4] |->
      radio_on_o == host_pins_i.flight_n;
  endproperty
  a_fl: assert property (p_fl) else $error("flight");
endmodule

bind swss_top swss_top_chk #(.RING_HALF(RING_HALF)) u_swss_top_chk (.*);

// ---- dv/swss_top_tb.sv ----
// Self-checking bench for swss_top with shortened counts.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
module swss_top_tb;
  import swss_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ring_event_i = 1'b0;
  logic ring_clear_i = 1'b0;
  logic host_awake_pol_i = 1'b1;
  logic voice_sms_active_i = 1'b0;
  swss_net_e net_state_i = SWSS_NET_NONE;
  swss_host_s host_pins_i;
  swss_od_s network_led_out_o;
  logic usb_off_command_i, slow_clock_command_i, host_wake_ring_out_o;
  logic status_o, status_oe_o, asleep_o, host_awake_o, radio_on_o;
  logic wake_event_o;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  int n_wake = 0;
  // Counts wake pulses as the design shows them
  always @(posedge mclk_i) begin
    if (wake_event_o === 1'b1) begin
      n_wake++;
    end
  end
  always #10 mclk_i = ~mclk_i;
  swss_top #(.RING_HALF(8), .SLOW_HALF(40), .FAST_HALF(10)) u_swss_top (.*);
  swss_host_model u_swss_host_model (.mclk_i, .host_pins_o(host_pins_i),
    .usb_off_o(usb_off_command_i), .slow_clk_o(slow_clock_command_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask
  function automatic logic sg(input bit s);
    return s ? network_led_out_o.led_oe : host_wake_ring_out_o;
  endfunction
  // Cycles until the line changes; 99 means it stayed put
  task automatic run(input bit s);
    logic v;
    v = sg(s);
    n = 0;
    while (sg(s) === v && n < 99) begin
      step(1);
      n++;
    end
  endtask
  task automatic t_ring();
    chk(host_wake_ring_out_o, 0);
    ring_event_i = 1'b1;
    step(1);
    ring_event_i = 1'b0;
    run(0);
    chk(n, 1);
    repeat (2) begin
      run(0);
      chk(n, 8);
    end
    ring_clear_i = 1'b1;
    step(1);
    ring_clear_i = 1'b0;
    step(20);
    chk(host_wake_ring_out_o, 0);
  endtask
  task automatic t_led(input swss_net_e s, input logic v, input int e);
    net_state_i = s;
    voice_sms_active_i = v;
    repeat (3) run(1);
    chk(n, e);
    chk(network_led_out_o.led_o, 1'b0);
    if (e == 99) chk(network_led_out_o.led_oe, 1'b1);
  endtask
  task automatic t_sleep(input bit d);
    int w;
    u_swss_host_model.sleep_req();
    chk(asleep_o, 1);
    w = n_wake;
    u_swss_host_model.wake(d);
    chk(asleep_o, 0);
    chk(n_wake - w, 1);
  endtask
  task automatic t_pin(input logic p, input logic a, input logic f);
    host_awake_pol_i = p;
    u_swss_host_model.put({2'b11, a, f});
    step(5);
    chk(host_awake_o, a == p);
    chk(radio_on_o, f);
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    #2;
    rst_i = 1'b0;
    step(1);
    chk(status_oe_o, 1);
    chk(status_o, 0);
    t_ring();
    t_led(SWSS_NET_NONE, 1'b0, 99);
    t_led(SWSS_NET_2G3G, 1'b0, 40);
    t_led(SWSS_NET_4G, 1'b0, 10);
    t_led(SWSS_NET_NONE, 1'b1, 10);
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_pin(1'b1, 1'b1, 1'b0);
    t_pin(1'b1, 1'b0, 1'b1);
    t_pin(1'b0, 1'b0, 1'b0);
    t_pin(1'b0, 1'b1, 1'b1);
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule

// ---- verilog/swss_pkg.sv ----
// Package for the sleep/wake and status signalling block.
// Assumes a single 50 MHz clock domain.
package swss_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RING_HALF_MS = 250;
  localparam int unsigned RING_HALF_CYC = RING_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned LED_SLOW_HALF_MS = 1000;
  localparam int unsigned LED_FAST_HALF_MS = 250;
  localparam int unsigned LED_SLOW_HALF_CYC =
    LED_SLOW_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned LED_FAST_HALF_CYC =
    LED_FAST_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic RING_RST = 1'b0;
  localparam logic SLEEP_RST = 1'b0;

  typedef enum logic [1:0] {
    SWSS_NET_NONE = 2'h0,
    SWSS_NET_2G3G = 2'h1,
    SWSS_NET_4G = 2'h2
  } swss_net_e;

  typedef enum logic [2:0] {
    SWSS_AWAKE = 3'b001,
    SWSS_ARMED = 3'b010,
    SWSS_ASLEEP = 3'b100
  } swss_pwr_e;

  typedef struct packed {
    logic terminal_ready;
    logic wake_request;
    logic host_awake;
    logic flight_n;
  } swss_host_s;

  typedef struct packed {
    logic led_o;
    logic led_oe;
  } swss_od_s;

endpackage

// ---- verilog/swss_sync.sv ----
// Two-stage synchroniser for a bundle of host input pins.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/10ps
module swss_sync #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W == 0) begin : g_bad_width
    $error("swss_sync: width must be non-zero");
  end

  // Both stages reset to the idle level, so no false request after reset
  // First stage feeds only the second one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// ---- verilog/swss_top.sv ----
// Sideband signalling: ring wake output, sleep control, host-ready
// sensing, flight mode, network LED and power-on status pin.
// Assumes one 50 MHz clock; all host pins are asynchronous.
`timescale 1ns/10ps
// Contract
// RULE1 - Ring output stays low while no incoming event is pending.
// RULE2 - Incoming call or SMS gives 250 ms high, 250 ms low ring wave.
// RULE3 - Terminal-ready driven low while asleep wakes the device.
// RULE4 - Ready high, then usb-off and slow-clock commands, gives sleep.
// RULE5 - Low level on dedicated wake input is a wake request.
// RULE6 - Host-ready input sampled with selectable active polarity.
// RULE7 - Flight input low turns radio off; release restores it.
// RULE8 - Network LED is open drain, never driven high.
// RULE9 - LED steady with no service; slow flash non-4G; fast flash 4G/voice.
// RULE10 - Status pin driven low while powered, otherwise high impedance.
// RULE11 - Flash rates are parameters; fast rate above slow rate.
// RULE12 - Host inputs pass a two-flop synchroniser before use.
module swss_top
  import swss_pkg::*;
#(
  parameter int unsigned RING_HALF = RING_HALF_CYC,
  parameter int unsigned SLOW_HALF = LED_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = LED_FAST_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host pins
  input wire swss_pkg::swss_host_s host_pins_i,
  // Internal events and status
  input wire logic ring_event_i,
  input wire logic ring_clear_i,
  input wire logic usb_off_command_i,
  input wire logic slow_clock_command_i,
  input wire logic host_awake_pol_i,
  input wire swss_pkg::swss_net_e net_state_i,
  input wire logic voice_sms_active_i,
  // Pin outputs
  output logic host_wake_ring_out_o,
  output swss_pkg::swss_od_s network_led_out_o,
  output logic status_o,
  output logic status_oe_o,
  // State outputs
  output logic asleep_o,
  output logic host_awake_o,
  output logic radio_on_o,
  output logic wake_event_o
);
  import swss_pkg::*;

  // Counters need a non-zero half period
  if (RING_HALF == 0) begin : g_bad_ring
    $error("swss_top: ring half period must be non-zero");
  end
  if (FAST_HALF == 0) begin : g_bad_fast
    $error("swss_top: fast flash half period must be non-zero");
  end
  // Fast flash must stay distinguishable from slow flash
  if (FAST_HALF >= SLOW_HALF) begin : g_bad_rates // RULE11
    $error("swss_top: fast flash must be faster than slow flash");
  end

  // Last cycle of a half period; ring and LED share it
  function automatic logic half_end(input logic [31:0] cnt,
                                    input logic [31:0] half);
    return (cnt >= half - 32'h1) ? 1'b1 : 1'b0;
  endfunction

  swss_host_s hs;
  // Reset levels: host pins idle high (not requesting)
  swss_sync #(
    .W(4),
    .RST_VAL(4'hf)
  ) u_sync ( // RULE12
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(host_pins_i),
    .sync_o(hs)
  );

  // Ring generator
  logic ring_pend_q;
  logic [31:0] ring_cnt_q;
  logic ring_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_pend_q <= 1'b0;
    end else if (ring_event_i) begin
      ring_pend_q <= 1'b1; // Set wins over clear
    end else if (ring_clear_i) begin
      ring_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_cnt_q <= 32'(RING_HALF - 1);
      ring_q <= RING_RST;
    end else if (!ring_pend_q) begin
      // Preloaded so the wave opens with a full high phase
      ring_cnt_q <= 32'(RING_HALF - 1);
      ring_q <= 1'b0; // RULE1
    end else if (half_end(ring_cnt_q, 32'(RING_HALF))) begin
      ring_cnt_q <= '0;
      ring_q <= ~ring_q; // RULE2
    end else begin
      ring_cnt_q <= ring_cnt_q + 32'h1;
    end
  end
  assign host_wake_ring_out_o = ring_q;

  // Sleep control
  swss_pwr_e pwr_q;
  logic asleep_q;
  logic wake_q;
  logic wake_req;
  logic sleep_go;
  logic wake_go;
  // Either host pin pulled low asks for wake
  assign wake_req = !hs.wake_request || !hs.terminal_ready; // RULE3 RULE5
  assign sleep_go = (pwr_q == SWSS_ARMED) && hs.terminal_ready &&
                    slow_clock_command_i;
  assign wake_go = (pwr_q == SWSS_ASLEEP) && wake_req;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= SWSS_AWAKE;
    end else begin
      case (pwr_q)
        SWSS_AWAKE: begin
          if (hs.terminal_ready && usb_off_command_i) begin
            pwr_q <= SWSS_ARMED; // RULE4
          end
        end
        SWSS_ARMED: begin
          // Ready dropped between the commands: entry is abandoned
          if (!hs.terminal_ready) begin
            pwr_q <= SWSS_AWAKE;
          end else if (sleep_go) begin
            pwr_q <= SWSS_ASLEEP; // RULE4
          end
        end
        SWSS_ASLEEP: begin
          if (wake_go) begin
            pwr_q <= SWSS_AWAKE; // RULE3 RULE5
          end
        end
        default: begin
          pwr_q <= SWSS_AWAKE;
        end
      endcase
    end
  end

  // Sleep flag is its own flop so the output never glitches on decode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      asleep_q <= SLEEP_RST;
    end else if (sleep_go) begin
      asleep_q <= 1'b1;
    end else if (wake_go || pwr_q != SWSS_ASLEEP) begin
      asleep_q <= 1'b0;
    end
  end

  // One-cycle pulse on the edge that leaves sleep
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_go; // RULE3 RULE5
    end
  end
  assign asleep_o = asleep_q;
  assign wake_event_o = wake_q;

  // Host-ready and flight mode
  logic host_awake_q;
  logic radio_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      host_awake_q <= 1'b0;
    end else begin
      host_awake_q <= hs.host_awake ~^ host_awake_pol_i; // RULE6
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      radio_q <= 1'b0;
    end else begin
      radio_q <= hs.flight_n; // RULE7
    end
  end
  assign host_awake_o = host_awake_q;
  assign radio_on_o = radio_q;

  // Network LED: low pulls the LED on
  logic [31:0] led_cnt_q;
  logic led_phase_q;
  logic led_on;
  logic [31:0] led_half;
  swss_od_s led_q;
  assign led_half = (net_state_i == SWSS_NET_4G || voice_sms_active_i) ?
                    32'(FAST_HALF) : 32'(SLOW_HALF); // RULE11
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      led_cnt_q <= '0;
      led_phase_q <= 1'b0;
    end else if (half_end(led_cnt_q, led_half)) begin
      led_cnt_q <= '0;
      led_phase_q <= ~led_phase_q;
    end else begin
      led_cnt_q <= led_cnt_q + 32'h1;
    end
  end
  assign led_on = (net_state_i == SWSS_NET_NONE &&
                   !voice_sms_active_i) ? 1'b1 : led_phase_q; // RULE9
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      led_q <= '0;
    end else begin
      led_q.led_o <= 1'b0; // RULE8
      led_q.led_oe <= led_on;
    end
  end
  assign network_led_out_o = led_q;

  // Status pin: pulled low once out of reset; the pull-up is external
  logic status_q;
  logic status_oe_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 1'b0;
      status_oe_q <= 1'b0;
    end else begin
      status_q <= 1'b0; // RULE10
      status_oe_q <= 1'b1; // RULE10
    end
  end
  assign status_o = status_q;
  assign status_oe_o = status_oe_q;
endmodule
